/* File: ofi_irq_out.sv */
// oscillator-fail flag, interrupt combine and shared open-drain pin
// assumes event inputs are synchronous pulses/levels on ref_clk_i
`timescale 1ns/1ps
// Overview of operation
// - oscillator stop sets osc-fail flag
// - halt kick bit also sets flag
// - first power-up flag comes up set
// - flag sticky until written zero
// - detection works in backup mode
// - enabled flag asserts pin until cleared
// - enable clear drops, re-set reasserts pin
// - four sources ORed into primary request
// - freq test puts 512 Hz on pin
// - backup disables timer and watchdog sources
// - main supply: level 0, ft 0 gives 0
// - main supply: ft gives 512 Hz cases
// - main supply: level 1 with irqs follows irq
// - main supply: level 1, ft 0, nothing enabled is 1
// - backup: backup enable 0 gives 1
// - backup: level 0 gives 0, level 1 nothing enabled 1
// - backup irq needs level, backup en, enables
// - level bit7, ft bit6 of 08h
// - backup en, alarm en 0Ah; osc_fail_irq_en 09h
// - first and later power-up defaults
// - flags read clears timer flag
module ofi_irq_out
    import ofi_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            rst_n_i,
    // power state
    input  wire logic            first_pwrup_i,   // no battery history
    input  wire logic            backup_mode_i,   // running on battery
    input  wire ofi_pkg::ofi_evt_s evt_i,         // source events
    // ahb-lite slave
    input  wire logic            hsel_i,
    input  wire logic [31:0]     haddr_i,
    input  wire logic [1:0]      htrans_i,
    input  wire logic            hwrite_i,
    input  wire logic [2:0]      hsize_i,
    input  wire logic [31:0]     hwdata_i,
    input  wire logic            hready_i,
    output logic      [31:0]     hrdata_o,
    output logic                 hreadyout_o,
    output logic                 hresp_o,
    // shared open-drain pin
    input  wire logic            shared_irq_pin_i,
    output logic                 shared_irq_pin_o,
    output logic                 shared_irq_pin_oe_o
);
    import ofi_pkg::*;

    // ==========================================================
    // register state
    logic       out_level_q;    // pin-level bit
    logic       freq_test_en_q;
    logic       osc_fail_irq_en_q;
    logic       alarm1_irq_en_q;
    logic       square_wave_en_q;
    logic       backup_irq_en_q;
    logic       timer_irq_en_q;
    logic       wdog_en_q;
    logic       osc_halt_kick_q;
    logic [1:0] century_q;      // century_count_hi/lo
    logic       osc_fail_flag_q;
    logic       timer_flag_q;
    logic       alarm1_flag_q;
    logic       wdog_flag_q;
    logic       init_done_q;    // power-up defaults applied
    logic       pin_q;          // pin level registered
    // bus data-phase capture
    logic       dp_wr_q;
    logic       dp_rd_q;
    logic [7:0] dp_addr_q;
    logic       pin_s1_q;
    logic       pin_s2_q;       // synchronised pin readback

    // ==========================================================
    // ahb-lite address phase, zero wait states
    wire addr_ok = hsel_i && hready_i && htrans_i[1];
    wire [31:0] wd = hwdata_i;
    wire wr_en = dp_wr_q;
    wire rd_flags = dp_rd_q && (dp_addr_q == OFI_ADDR_FLAGS);

    // address/data-phase pipeline
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dp_wr_q   <= 1'b0;
            dp_rd_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end
        else if (hready_i)
        begin
            dp_wr_q   <= addr_ok && hwrite_i;
            dp_rd_q   <= addr_ok && !hwrite_i;
            dp_addr_q <= haddr_i[7:0];
        end
    end

    // always ready, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // ==========================================================
    // pin readback synchroniser
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= shared_irq_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ==========================================================
    // power-up sequencing and the bits every power-up clears
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // freq test and watchdog clear each time
            init_done_q    <= 1'b0;
            freq_test_en_q <= 1'b0;
            wdog_en_q      <= 1'b0;
        end
        else if (!init_done_q)
            init_done_q <= 1'b1;
        else if (wr_en && (dp_addr_q == OFI_ADDR_CAL))
            freq_test_en_q <= wd[OFI_CAL_FT];
        else if (wr_en && (dp_addr_q == OFI_ADDR_CTRL))
            wdog_en_q <= wd[OFI_CTL_WDEN];
    end

    // battery-backed bits: no reset, so a later power-up keeps them
    always_ff @(posedge ref_clk_i)
    begin
        if (!init_done_q)
        begin
            // defaults only on the first power-up
            if (first_pwrup_i)
            begin
                out_level_q       <= 1'b1;
                osc_fail_irq_en_q <= 1'b0;
                alarm1_irq_en_q   <= 1'b0;
                square_wave_en_q  <= 1'b1;
                backup_irq_en_q   <= 1'b0;
                timer_irq_en_q    <= 1'b0;
                osc_halt_kick_q   <= 1'b0;
                century_q         <= 2'b00;
            end
        end
        else if (wr_en)
        begin
            case (dp_addr_q)
                OFI_ADDR_CAL:
                    out_level_q <= wd[OFI_CAL_OUT];
                OFI_ADDR_WDOG:
                    osc_fail_irq_en_q <= wd[OFI_WD_OSC_FAIL_IRQ_EN];
                OFI_ADDR_ALM:
                begin
                    alarm1_irq_en_q  <= wd[OFI_ALM_ALARM1_IRQ_EN];
                    square_wave_en_q <= wd[OFI_ALM_SQUARE_WAVE_EN];
                    backup_irq_en_q  <= wd[OFI_ALM_ABE];
                end
                OFI_ADDR_CTRL:
                begin
                    osc_halt_kick_q <= wd[OFI_CTL_HALT];
                    timer_irq_en_q  <= wd[OFI_CTL_TIE];
                    century_q       <= wd[OFI_CTL_CENT+1:OFI_CTL_CENT];
                end
                default:
                    ; // other addresses hold state
            endcase
        end
    end

    // ==========================================================
    // oscillator-fail flag: set beats clear
    wire wr_flags = wr_en && (dp_addr_q == OFI_ADDR_FLAGS);
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            osc_fail_flag_q <= 1'b1;
        else if (evt_i.osc_stop || osc_halt_kick_q)
            osc_fail_flag_q <= 1'b1;
        else if (wr_flags && !wd[OFI_FLG_OF])
            osc_fail_flag_q <= 1'b0;
    end

    // ==========================================================
    // other source flags; timer and watchdog idle in backup
    // backup gates timer and watchdog events
    wire tmr_set = evt_i.timer_evt && !backup_mode_i;
    wire wd_set  = evt_i.wdog_evt && wdog_en_q && !backup_mode_i;
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            timer_flag_q  <= 1'b0;
            alarm1_flag_q <= 1'b0;
            wdog_flag_q   <= 1'b0;
        end
        else
        begin
            if (tmr_set)
                timer_flag_q <= 1'b1;
            else if (rd_flags)
                timer_flag_q <= 1'b0;
            if (evt_i.alarm1_evt)
                alarm1_flag_q <= 1'b1;
            else if (wr_flags && !wd[OFI_FLG_AF])
                alarm1_flag_q <= 1'b0;
            if (wd_set)
                wdog_flag_q <= 1'b1;
            else if (wr_flags && !wd[OFI_FLG_WDF])
                wdog_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // primary request and enable summary
    // level OR of enabled flags
    wire irq_vcc = (osc_fail_flag_q && osc_fail_irq_en_q) ||
                   (alarm1_flag_q && alarm1_irq_en_q) ||
                   (timer_flag_q && timer_irq_en_q) ||
                   (wdog_flag_q && wdog_en_q);
    // only alarm 1 and osc-fail in backup
    wire irq_bak = (osc_fail_flag_q && osc_fail_irq_en_q) ||
                   (alarm1_flag_q && alarm1_irq_en_q);
    wire any_en_vcc = alarm1_irq_en_q || osc_fail_irq_en_q ||
                      timer_irq_en_q || wdog_en_q;
    wire any_en_bak = alarm1_irq_en_q || osc_fail_irq_en_q;

    // ==========================================================
    // 512 Hz frequency-test divider
    localparam int FTW = $clog2(OFI_FT_HALF);
    localparam logic [FTW-1:0] FT_LAST = FTW'(OFI_FT_HALF - 1);
    logic [FTW-1:0] ft_cnt_q;
    logic           ft_wave_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ft_cnt_q  <= '0;
            ft_wave_q <= 1'b0;
        end
        else if (ft_cnt_q == FT_LAST)
        begin
            ft_cnt_q  <= '0;
            ft_wave_q <= !ft_wave_q;
        end
        else
            ft_cnt_q <= ft_cnt_q + 1'b1;
    end

    // ==========================================================
    // pin source selection
    ofi_pin_e sel;
    always_comb
    begin
        sel = OFI_PIN_HIGH;
        if (backup_mode_i)
        begin
            if (!backup_irq_en_q)
                sel = OFI_PIN_HIGH;
            else if (!out_level_q)
                sel = OFI_PIN_LOW;
            else if (any_en_bak)
                sel = OFI_PIN_IRQ;
            else
                sel = OFI_PIN_HIGH;
        end
        else
        begin
            if (!out_level_q && !freq_test_en_q)
                sel = OFI_PIN_LOW;
            else if (freq_test_en_q && (!out_level_q || !any_en_vcc))
                sel = OFI_PIN_FT;
            else if (any_en_vcc)
                sel = OFI_PIN_IRQ;
            else
                sel = OFI_PIN_HIGH;
        end
    end

    // registered pin level
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pin_q <= 1'b1;
        else
        begin
            case (sel)
                OFI_PIN_LOW:  pin_q <= 1'b0;
                OFI_PIN_FT:   pin_q <= ft_wave_q;
                OFI_PIN_IRQ:  pin_q <= backup_mode_i ? !irq_bak : !irq_vcc;
                default:      pin_q <= 1'b1;
            endcase
        end
    end

    // open drain: drive only the low level
    assign shared_irq_pin_o    = 1'b0;
    assign shared_irq_pin_oe_o = !pin_q;

    // ==========================================================
    // read data mux
    always_comb
    begin
        hrdata_o = 32'h0000_0000;
        if (dp_rd_q)
        begin
            case (dp_addr_q)
                OFI_ADDR_CAL:
                begin
                    hrdata_o[OFI_CAL_OUT] = out_level_q;
                    hrdata_o[OFI_CAL_FT]  = freq_test_en_q;
                end
                OFI_ADDR_WDOG:
                    hrdata_o[OFI_WD_OSC_FAIL_IRQ_EN] = osc_fail_irq_en_q;
                OFI_ADDR_ALM:
                begin
                    hrdata_o[OFI_ALM_ALARM1_IRQ_EN] = alarm1_irq_en_q;
                    hrdata_o[OFI_ALM_SQUARE_WAVE_EN] = square_wave_en_q;
                    hrdata_o[OFI_ALM_ABE]  = backup_irq_en_q;
                end
                OFI_ADDR_FLAGS:
                begin
                    hrdata_o[OFI_FLG_WDF] = wdog_flag_q;
                    hrdata_o[OFI_FLG_AF]  = alarm1_flag_q;
                    hrdata_o[OFI_FLG_OF]  = osc_fail_flag_q;
                    hrdata_o[OFI_FLG_TF]  = timer_flag_q;
                end
                OFI_ADDR_CTRL:
                begin
                    hrdata_o[OFI_CTL_HALT] = osc_halt_kick_q;
                    hrdata_o[OFI_CTL_TIE]  = timer_irq_en_q;
                    hrdata_o[OFI_CTL_WDEN] = wdog_en_q;
                    hrdata_o[OFI_CTL_CENT+1:OFI_CTL_CENT] = century_q;
                end
                OFI_ADDR_STAT:
                begin
                    hrdata_o[0] = pin_s2_q;
                    hrdata_o[1] = irq_vcc;
                    hrdata_o[2] = irq_bak;
                end
                default:
                    hrdata_o = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // checks
    // flag holds across a flags read
    a_flag_read_keeps: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (osc_fail_flag_q && !wr_flags) |=> osc_fail_flag_q)
        else $error("osc-fail flag dropped without write");
    a_halt_sets_flag: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        osc_halt_kick_q |=> osc_fail_flag_q)
        else $error("halt kick did not set flag");
    a_vcc_level_low: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (!backup_mode_i && !out_level_q && !freq_test_en_q)
        |=> !pin_q)
        else $error("pin not low for level zero");
    a_bak_release: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (backup_mode_i && !backup_irq_en_q) |=> pin_q)
        else $error("pin low in backup without enable");
    a_osc_fail_irq_en_assert: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (!backup_mode_i && out_level_q && !freq_test_en_q &&
         osc_fail_flag_q && osc_fail_irq_en_q) |=> !pin_q)
        else $error("osc-fail irq not on pin");
    a_tf_read_clr: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (rd_flags && !tmr_set) |=> !timer_flag_q)
        else $error("timer flag survived read");
    a_bak_no_wdog: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (backup_mode_i && !wdog_flag_q && !wr_en) |=> !wdog_flag_q)
        else $error("watchdog flag set in backup");
    a_vcc_idle_high: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (!backup_mode_i && out_level_q && !freq_test_en_q &&
         !any_en_vcc) |=> pin_q)
        else $error("pin low with nothing enabled");
endmodule

/* File: ofi_pkg.sv */
// package for the oscillator-fail flag and shared interrupt pin block
// assumes a single 100 MHz clock and an AHB-Lite register slave
package ofi_pkg;
    // ==========================================================
    // register byte addresses (printed offsets are byte aligned)
    localparam logic [7:0] OFI_ADDR_CAL   = 8'h08; // pin level, freq test
    localparam logic [7:0] OFI_ADDR_WDOG  = 8'h09; // osc-fail irq enable
    localparam logic [7:0] OFI_ADDR_ALM   = 8'h0a; // alarm1 en, backup en
    localparam logic [7:0] OFI_ADDR_FLAGS = 8'h0f; // flags
    localparam logic [7:0] OFI_ADDR_CTRL  = 8'h20; // halt, timer en, wdog en, century
    localparam logic [7:0] OFI_ADDR_STAT  = 8'h24; // pin state, sources
    // ==========================================================
    // field positions
    localparam int OFI_CAL_OUT    = 7; // pin-level bit
    localparam int OFI_CAL_FT     = 6; // frequency test enable
    localparam int OFI_WD_OSC_FAIL_IRQ_EN    = 7; // osc-fail irq enable
    localparam int OFI_ALM_ALARM1_IRQ_EN   = 7; // alarm 1 irq enable
    localparam int OFI_ALM_SQUARE_WAVE_EN   = 6; // square wave enable
    localparam int OFI_ALM_ABE    = 5; // irq enable in backup
    localparam int OFI_FLG_WDF    = 7; // watchdog flag
    localparam int OFI_FLG_AF     = 6; // alarm 1 flag
    localparam int OFI_FLG_OF     = 2; // osc-fail flag
    localparam int OFI_FLG_TF     = 0; // timer flag
    localparam int OFI_CTL_HALT   = 0; // oscillator halt kick
    localparam int OFI_CTL_TIE    = 1; // timer irq enable
    localparam int OFI_CTL_WDEN   = 2; // watchdog running
    localparam int OFI_CTL_CENT   = 4; // century bits 5:4
    // ==========================================================
    // timing
    localparam int OFI_CLK_HZ     = 100_000_000;
    localparam int OFI_FT_HZ      = 512;
    localparam int OFI_FT_HALF    = OFI_CLK_HZ / (2 * OFI_FT_HZ);
    // ==========================================================
    // pin source select
    typedef enum logic [2:0] {
        OFI_PIN_LOW   = 3'b000,
        OFI_PIN_HIGH  = 3'b001,
        OFI_PIN_FT    = 3'b010,
        OFI_PIN_IRQ   = 3'b011
    } ofi_pin_e;
    // event inputs from the neighbouring blocks
    typedef struct packed {
        logic osc_stop;   // oscillator stopped
        logic timer_evt;  // timer reload
        logic alarm1_evt; // alarm 1 match
        logic wdog_evt;   // watchdog timeout
    } ofi_evt_s;
endpackage

/* File: ofi_host_model.sv */
// host side of the shared open-drain interrupt pin
// assumes the device only ever pulls the pin low
`timescale 1ns/1ps
module ofi_host_model
(
    // open-drain drive from the device
    input  wire logic pin_oe_i,  // device pulling the pin
    input  wire logic pin_o_i,   // value driven while enabled
    // resolved wire
    output logic      pin_lvl_o  // level seen by host and device
);
    // ==========================================================
    // pull-up resistor: a released pin rises to 1
    assign pin_lvl_o = pin_oe_i ? pin_o_i : 1'b1;
endmodule

/* File: test_ofi_irq_out.sv */
// testbench for the osc-fail flag and shared irq pin block
// assumes ofi_pkg, ofi_irq_out and the pull-up host model
`timescale 1ns/1ps
module test_ofi_irq_out;
    import ofi_pkg::*;
    // ==========================================================
    // design signals
    logic        ref_clk_i;     // 100 MHz clock
    logic        rst_n_i;       // async reset
    logic        first_pwrup_i; // no battery history
    logic        backup_mode_i; // on battery
    ofi_evt_s    evt_i;         // source events
    logic        hsel_i;        // bus select
    logic [31:0] haddr_i;       // bus address
    logic [1:0]  htrans_i;      // bus transfer kind
    logic        hwrite_i;      // bus direction
    logic [2:0]  hsize_i;       // bus size
    logic [31:0] hwdata_i;      // bus write data
    logic [31:0] hrdata_o;      // bus read data
    logic        hreadyout_o;   // slave ready
    logic        hresp_o;       // slave response
    logic        pin_o;         // pin drive value
    logic        pin_oe;        // pin drive enable
    logic        pin_lvl;       // resolved pin
    // bench state
    int          n_fail;        // mismatches
    int          n_tests;       // comparisons
    int          cnt;           // cycle count
    logic        p;             // last pin level
    logic [31:0] d;             // read data
    logic [7:0]  en_a [3];      // enable register per source
    logic [7:0]  en_v [3];      // value with source enabled
    logic [7:0]  en_x [3];      // value with source disabled
    int          ev_k [3];      // event bit per source
    // ==========================================================
    // instances
    ofi_irq_out dut_u (
        .ref_clk_i           (ref_clk_i),
        .rst_n_i             (rst_n_i),
        .first_pwrup_i       (first_pwrup_i),
        .backup_mode_i       (backup_mode_i),
        .evt_i               (evt_i),
        .hsel_i              (hsel_i),
        .haddr_i             (haddr_i),
        .htrans_i            (htrans_i),
        .hwrite_i            (hwrite_i),
        .hsize_i             (hsize_i),
        .hwdata_i            (hwdata_i),
        .hready_i            (hreadyout_o),
        .hrdata_o            (hrdata_o),
        .hreadyout_o         (hreadyout_o),
        .hresp_o             (hresp_o),
        .shared_irq_pin_i    (pin_lvl),
        .shared_irq_pin_o    (pin_o),
        .shared_irq_pin_oe_o (pin_oe)
    );
    ofi_host_model host_u (
        .pin_oe_i  (pin_oe),
        .pin_o_i   (pin_o),
        .pin_lvl_o (pin_lvl)
    );
    // ==========================================================
    // clock
    always #5 ref_clk_i = ~ref_clk_i;
    // ==========================================================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // waits for a rising edge with ready high; data taken there
    task automatic wait_rdy(output logic [31:0] rd);
        do
            @(posedge ref_clk_i);
        while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    // one single word transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h000000, a};
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        wait_rdy(rd);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        wait_rdy(rd);
        chk("hresp", {31'h0, hresp_o}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h00000000, v);
    endtask
    // pin level once the selection has settled
    task automatic pin_is(input logic e);
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("pin", {31'h0, pin_lvl}, {31'h0, e});
        @(posedge ref_clk_i);
    endtask
    // one-cycle event pulse
    task automatic pulse(input int k);
        evt_i[k] <= 1'b1;
        @(posedge ref_clk_i);
        evt_i[k] <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // watchdog: the test needs roughly 100k cycles
    initial
    begin
        #1_100_000;
        n_fail++;
        end_of_test();
    end
    // ==========================================================
    // main sequence
    initial
    begin
        ref_clk_i = 1'b0;
        rst_n_i = 1'b0;
        first_pwrup_i = 1'b1;
        backup_mode_i = 1'b0;
        evt_i = '0;
        hsel_i = 1'b0;
        haddr_i = 32'h00000000;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h00000000;
        n_fail = 0;
        n_tests = 0;
        // sources: timer, alarm 1, watchdog
        en_a = '{OFI_ADDR_CTRL, OFI_ADDR_ALM, OFI_ADDR_CTRL};
        en_v = '{8'h02, 8'hc0, 8'h04};
        en_x = '{8'h00, 8'h40, 8'h00};
        ev_k = '{2, 1, 0};
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        // first power-up defaults
        rd(OFI_ADDR_FLAGS, d);
        chk("osc_fail_flag", d[OFI_FLG_OF], 1'b1);
        rd(OFI_ADDR_CAL, d);
        chk("cal", d[7:0], 8'h80);
        rd(OFI_ADDR_WDOG, d);
        chk("osc_fail_irq_en", d[OFI_WD_OSC_FAIL_IRQ_EN], 1'b0);
        rd(OFI_ADDR_ALM, d);
        chk("alm", d[7:5], 3'b010);
        rd(OFI_ADDR_CTRL, d);
        chk("ctrl", d[5:0], 6'h00);
        rd(8'h40, d);
        chk("unmapped", d, 32'h00000000);
        pin_is(1'b1);
        rd(OFI_ADDR_FLAGS, d);
        chk("osc_fail_flag", d[OFI_FLG_OF], 1'b1);
        // settle wait before clearing, shortened for simulation
        repeat (20) @(posedge ref_clk_i);
        wr(OFI_ADDR_FLAGS, 32'h0);
        rd(OFI_ADDR_FLAGS, d);
        chk("osc_fail_flag", d[OFI_FLG_OF], 1'b0);
        // osc-fail interrupt path
        wr(OFI_ADDR_WDOG, 32'h80);
        pin_is(1'b1);
        pulse(3);
        rd(OFI_ADDR_FLAGS, d);
        chk("osc_fail_flag", d[OFI_FLG_OF], 1'b1);
        pin_is(1'b0);
        rd(OFI_ADDR_STAT, d);
        chk("stat", d[2:0], 3'b110);
        wr(OFI_ADDR_WDOG, 32'h0);
        pin_is(1'b1);
        wr(OFI_ADDR_WDOG, 32'h80);
        pin_is(1'b0);
        // kick while the flag is set; halt holds the flag
        wr(OFI_ADDR_CTRL, 32'h1);
        wr(OFI_ADDR_FLAGS, 32'h0);
        rd(OFI_ADDR_FLAGS, d);
        chk("osc_fail_flag", d[OFI_FLG_OF], 1'b1);
        wr(OFI_ADDR_CTRL, 32'h0);
        wr(OFI_ADDR_FLAGS, 32'h0);
        pin_is(1'b1);
        wr(OFI_ADDR_WDOG, 32'h0);
        // remaining sources, one at a time
        for (int k = 0; k < 3; k++)
        begin
            wr(en_a[k], {24'h0, en_v[k]});
            pin_is(1'b1);
            pulse(ev_k[k]);
            pin_is(1'b0);
            rd(OFI_ADDR_FLAGS, d);
            if (k == 0)
                pin_is(1'b1);
            wr(OFI_ADDR_FLAGS, 32'h0);
            pin_is(1'b1);
            wr(en_a[k], {24'h0, en_x[k]});
        end
        // level low dominates enabled interrupts
        wr(OFI_ADDR_WDOG, 32'h80);
        wr(OFI_ADDR_CAL, 32'h0);
        pin_is(1'b0);
        // frequency test with nothing enabled
        wr(OFI_ADDR_WDOG, 32'h0);
        wr(OFI_ADDR_CAL, 32'hc0);
        @(negedge ref_clk_i);
        p = pin_lvl;
        cnt = 0;
        while (pin_lvl === p && cnt < OFI_FT_HALF + 8)
        begin
            @(negedge ref_clk_i);
            cnt++;
        end
        chk("ft_edge", {31'h0, cnt <= OFI_FT_HALF + 4}, 32'h1);
        p = pin_lvl;
        cnt = 0;
        repeat (1000)
        begin
            @(negedge ref_clk_i);
            cnt += (pin_lvl !== p);
        end
        chk("ft_hold", cnt, 32'h0);
        @(posedge ref_clk_i);
        wr(OFI_ADDR_WDOG, 32'h80);
        pin_is(1'b1);
        // backup mode
        wr(OFI_ADDR_CAL, 32'h80);
        backup_mode_i <= 1'b1;
        pulse(3);
        pin_is(1'b1);
        rd(OFI_ADDR_FLAGS, d);
        chk("osc_fail_flag", d[OFI_FLG_OF], 1'b1);
        wr(OFI_ADDR_ALM, 32'h60);
        pin_is(1'b0);
        wr(OFI_ADDR_FLAGS, 32'h0);
        pin_is(1'b1);
        wr(OFI_ADDR_CAL, 32'h40);
        pin_is(1'b0);
        wr(OFI_ADDR_WDOG, 32'h0);
        wr(OFI_ADDR_CAL, 32'hc0);
        pin_is(1'b1);
        wr(OFI_ADDR_CTRL, 32'h6);
        pulse(2);
        pulse(0);
        pin_is(1'b1);
        rd(OFI_ADDR_FLAGS, d);
        chk("bak_flags", {d[OFI_FLG_WDF], d[OFI_FLG_TF]}, 2'b00);
        // later power-up with battery history
        wr(OFI_ADDR_WDOG, 32'h80);
        rst_n_i <= 1'b0;
        first_pwrup_i <= 1'b0;
        backup_mode_i <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rd(OFI_ADDR_CAL, d);
        chk("cal", d[7:0], 8'h80);
        rd(OFI_ADDR_WDOG, d);
        chk("osc_fail_irq_en", d[OFI_WD_OSC_FAIL_IRQ_EN], 1'b1);
        rd(OFI_ADDR_ALM, d);
        chk("alm", d[7:5], 3'b011);
        rd(OFI_ADDR_CTRL, d);
        chk("wdog_run", d[OFI_CTL_WDEN], 1'b0);
        chk("timer_irq_en", d[OFI_CTL_TIE], 1'b1);
        end_of_test();
    end
endmodule
